/* verilog/mgp_ports.sv */
// register, pin and analog mux logic for ports e, f, g and h
`timescale 1ns/1ps
`include "mgp_consts.svh"
module mgp_ports
   import mgp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire mgp_bus_t bus,
   output logic [7:0] rdData,
   input wire logic busMode,
   input wire logic busAle,
   input wire logic busOeN,
   input wire logic busWrN,
   input wire logic [15:0] capFourValue,
   input wire logic pwmThree,
   input wire logic serialTwoTxOe,
   input wire logic serialTwoTx,
   input wire logic serialTwoDtOe,
   input wire logic serialTwoDt,
   input wire logic [3:0] portEIn,
   output logic [3:0] portEOut,
   output logic [3:0] portEOeN,
   input wire logic [7:0] portFIn,
   output logic [7:0] portFOut,
   output logic [7:0] portFOeN,
   input wire logic [7:0] portGIn,
   output logic [7:0] portGOut,
   output logic [7:0] portGOeN,
   input wire logic [7:0] portHIn,
   output logic [7:0] portHOut,
   output logic [7:0] portHOeN,
   output logic [11:0] analogSel,
   output logic [3:0] analogSelHigh,
   output logic captureThreeIn,
   output logic captureFourIn,
   output logic serialTwoRx,
   output logic serialTwoClkIn,
   output logic [3:0] portConfig,
   output logic pwmThreeEnable
);
   mgp_state_t st_r;
   mgp_state_t st_nxt;
   logic [3:0] pcfg;
   logic fAna;
   logic gAna;
   logic hAna;
   logic [7:0] fPins;
   logic [7:0] gPins;
   logic [7:0] hPins;
   logic [3:0] ePins;

   // ------------------------------------------------------------
   // analog group decode
   // ------------------------------------------------------------
   // full converter encoding lives elsewhere; only the all-digital code
   // and the one code above it release pins here, anything else is analog
   always_comb begin
      pcfg = st_r.adcCon1[3:0];
      fAna = (pcfg < `MGP_PCFG_ALL_DIG); // RL18
      gAna = (pcfg < `MGP_PCFG_ALL_DIG); // RL18
      hAna = (pcfg < `MGP_PCFG_ALL_DIG); // RL18
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // analog pins read as zero, as digital buffers are off
      ePins = portEIn;
      fPins = fAna ? 8'h00 : portFIn; // RL14
      gPins = {portGIn[7:4], gAna ? 4'h0 : portGIn[3:0]};
      hPins = {hAna ? 4'h0 : portHIn[7:4], portHIn[3:0]};
      if (bus.wrEn) begin
         if (bus.bank == `MGP_BANK_E) begin
            if (bus.addr == `MGP_OFS_E_DIR) begin
               st_nxt.eDir = bus.wrData[3:0];
            end else if (bus.addr == `MGP_OFS_E_PIN) begin
               st_nxt.eLat = bus.wrData[3:0]; // RL3
            end
         end else if (bus.bank == `MGP_BANK_FG) begin
            if (bus.addr == `MGP_OFS_DIR_LO) begin
               st_nxt.fDir = bus.wrData;
            end else if (bus.addr == `MGP_OFS_PIN_LO) begin
               st_nxt.fLat = bus.wrData; // RL3
            end else if (bus.addr == `MGP_OFS_DIR_HI) begin
               st_nxt.gDir = bus.wrData;
            end else if (bus.addr == `MGP_OFS_PIN_HI) begin
               st_nxt.gLat = bus.wrData; // RL3
            end else if (bus.addr == `MGP_OFS_ADC1) begin
               st_nxt.adcCon1 = bus.wrData & `MGP_ADC1_MASK; // RL12
            end
         end else if (bus.bank == `MGP_BANK_CAP) begin
            if (bus.addr == `MGP_OFS_TIMER_CAPTURE_CONTROL_THREE) begin
               // overflow flags belong to the capture block
               st_nxt.timer_capture_control_three[4:0] = bus.wrData[4:0];
            end
         end else if (bus.bank == `MGP_BANK_H) begin
            if (bus.addr == `MGP_OFS_DIR_LO) begin
               st_nxt.hDir = bus.wrData;
            end else if (bus.addr == `MGP_OFS_PIN_LO) begin
               st_nxt.hLat = bus.wrData; // RL3
            end
         end
      end
      // reads sample pins, never the latch
      st_nxt.rdData = 8'h00; // RL12
      if (bus.rdEn) begin
         if (bus.bank == `MGP_BANK_E) begin
            if (bus.addr == `MGP_OFS_E_DIR) begin
               st_nxt.rdData = {4'h0, st_r.eDir}; // RL12
            end else if (bus.addr == `MGP_OFS_E_PIN) begin
               st_nxt.rdData = {4'h0, ePins}; // RL3 RL12
            end
         end else if (bus.bank == `MGP_BANK_FG) begin
            if (bus.addr == `MGP_OFS_DIR_LO) begin
               st_nxt.rdData = st_r.fDir;
            end else if (bus.addr == `MGP_OFS_PIN_LO) begin
               st_nxt.rdData = fPins; // RL3
            end else if (bus.addr == `MGP_OFS_DIR_HI) begin
               st_nxt.rdData = st_r.gDir;
            end else if (bus.addr == `MGP_OFS_PIN_HI) begin
               st_nxt.rdData = gPins; // RL3
            end else if (bus.addr == `MGP_OFS_ADC1) begin
               st_nxt.rdData = st_r.adcCon1;
            end
         end else if (bus.bank == `MGP_BANK_CAP) begin
            if (bus.addr == `MGP_OFS_CAP_LO) begin
               st_nxt.rdData = capFourValue[7:0]; // RL15
            end else if (bus.addr == `MGP_OFS_CAP_HI) begin
               st_nxt.rdData = capFourValue[15:8]; // RL15
            end else if (bus.addr == `MGP_OFS_TIMER_CAPTURE_CONTROL_THREE) begin
               st_nxt.rdData = st_r.timer_capture_control_three & `MGP_TIMER_CAPTURE_CONTROL_THREE_MASK; // RL12
            end
         end else if (bus.bank == `MGP_BANK_H) begin
            if (bus.addr == `MGP_OFS_DIR_LO) begin
               st_nxt.rdData = st_r.hDir;
            end else if (bus.addr == `MGP_OFS_PIN_LO) begin
               st_nxt.rdData = hPins; // RL3
            end
         end
      end

      // ------------------------------------------------------------
      // pin drivers
      // ------------------------------------------------------------
      st_nxt.eOut = st_nxt.eLat; // RL2
      st_nxt.eOeN = st_nxt.eDir; // RL1
      if (busMode) begin
         st_nxt.eOut[2:0] = {busWrN, busOeN, busAle}; // RL16 RL17
         st_nxt.eOeN[2:0] = 3'h0; // RL16
      end
      st_nxt.fOut = st_nxt.fLat; // RL2
      st_nxt.fOeN = st_nxt.fDir | {8{fAna}}; // RL1 RL5
      st_nxt.gOut = st_nxt.gLat; // RL2
      st_nxt.gOeN = st_nxt.gDir | {4'h0, {4{gAna}}}; // RL1 RL9
      if (st_nxt.timer_capture_control_three[0]) begin
         st_nxt.gOut[5] = pwmThree; // RL7
         st_nxt.gOeN[5] = 1'b0; // RL7
      end
      if (serialTwoDtOe) begin
         st_nxt.gOut[6] = serialTwoDt; // RL8
         st_nxt.gOeN[6] = 1'b0; // RL8
      end
      if (serialTwoTxOe) begin
         st_nxt.gOut[7] = serialTwoTx; // RL8
         st_nxt.gOeN[7] = 1'b0; // RL8
      end
      st_nxt.hOut = st_nxt.hLat; // RL2
      st_nxt.hOeN = st_nxt.hDir | {{4{hAna}}, 4'h0}; // RL1 RL11 RL10
      // bit k of the 12-bit select is analog channel k
      st_nxt.anaSel = {{8{fAna}}, {4{gAna}}}; // RL4 RL6
      st_nxt.anaSelHi = {4{hAna}}; // RL10
      st_nxt.cap3In = portGIn[4]; // RL7
      st_nxt.cap4In = portEIn[3];
      st_nxt.rx2In = portGIn[6]; // RL8
      st_nxt.ck2In = portGIn[7]; // RL8

      // ------------------------------------------------------------
      // reset
      // ------------------------------------------------------------
      if (rst) begin
         // latches are kept across reset except port f, which clears
         st_nxt.eDir = `MGP_E_DIR_RST; // RL13
         st_nxt.fDir = `MGP_DIR_RST; // RL14
         st_nxt.fLat = 8'h00; // RL14
         st_nxt.gDir = `MGP_DIR_RST;
         st_nxt.hDir = `MGP_DIR_RST;
         st_nxt.adcCon1 = `MGP_ADC1_RST; // RL5 RL9 RL11
         st_nxt.timer_capture_control_three = `MGP_TIMER_CAPTURE_CONTROL_THREE_RST;
         st_nxt.rdData = 8'h00;
         st_nxt.eOut = 4'h0;
         st_nxt.eOeN = 4'hf;
         st_nxt.fOut = 8'h00;
         st_nxt.fOeN = 8'hff;
         st_nxt.gOut = 8'h00;
         st_nxt.gOeN = 8'hff;
         st_nxt.hOut = 8'h00;
         st_nxt.hOeN = 8'hff;
         st_nxt.anaSel = 12'hfff; // RL4 RL6
         st_nxt.anaSelHi = 4'hf;
         st_nxt.cap3In = 1'b0;
         st_nxt.cap4In = 1'b0;
         st_nxt.rx2In = 1'b0;
         st_nxt.ck2In = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   assign rdData = st_r.rdData;
   assign portEOut = st_r.eOut;
   assign portEOeN = st_r.eOeN;
   assign portFOut = st_r.fOut;
   assign portFOeN = st_r.fOeN;
   assign portGOut = st_r.gOut;
   assign portGOeN = st_r.gOeN;
   assign portHOut = st_r.hOut;
   assign portHOeN = st_r.hOeN;
   assign analogSel = st_r.anaSel;
   assign analogSelHigh = st_r.anaSelHi;
   assign captureThreeIn = st_r.cap3In;
   assign captureFourIn = st_r.cap4In;
   assign serialTwoRx = st_r.rx2In;
   assign serialTwoClkIn = st_r.ck2In;
   assign portConfig = st_r.adcCon1[3:0];
   assign pwmThreeEnable = st_r.timer_capture_control_three[0];
endmodule : mgp_ports

/* common/mgp_consts.svh */
// constants for the multiplexed gpio ports e/f/g/h block
// Operation
// [RL1] direction bit one makes the pin an input, driver off
// [RL2] direction bit zero drives the pin from its latch bit
// [RL3] data reads return pin levels; writes only load the latch
// [RL4] port f bits 0..7 map to analog channels 4..11
// [RL5] every port f pin comes up analog after any reset
// [RL6] port g bits 0..3 map to analog channels 3..0
// [RL7] port g: bit4 capture three, bit5 pwm three, bits 6-7 serial two
// [RL8] port g bit6 receive/data, bit7 transmit/clock of serial two
// [RL9] port g bits 3..0 come up analog after any reset
// [RL10] port h upper nibble analog capable, lower nibble digital only
// [RL11] port h bits 7..4 come up analog after any reset
// [RL12] unimplemented register bits read as zero
// [RL13] port e direction resets to ones; its latch keeps value
// [RL14] port f direction resets to ones, data reads zero after reset
// [RL15] capture four result readable as low and high byte registers
// [RL16] in bus modes port e bits 2..0 carry ale, oe, wr strobes; the code puts wr, oe, ale on bits 2..0
// [RL17] output enable and write strobes are active low on the pins
// [RL18] port configuration field picks analog or digital per pin group; the code gives ports f, g and h one shared choice
// [RL19] software clears a latch before making pins outputs
`ifndef MGP_CONSTS_SVH
`define MGP_CONSTS_SVH
`define MGP_BANK_E 4'h1
`define MGP_BANK_FG 4'h5
`define MGP_BANK_CAP 4'h7
`define MGP_BANK_H 4'h8
`define MGP_OFS_DIR_LO 5'h10
`define MGP_OFS_PIN_LO 5'h11
`define MGP_OFS_DIR_HI 5'h12
`define MGP_OFS_PIN_HI 5'h13
`define MGP_OFS_E_DIR 5'h14
`define MGP_OFS_E_PIN 5'h15
`define MGP_OFS_CAP_LO 5'h14
`define MGP_OFS_CAP_HI 5'h15
`define MGP_OFS_ADC1 5'h15
`define MGP_OFS_TIMER_CAPTURE_CONTROL_THREE 5'h16
`define MGP_DIR_RST 8'hff
`define MGP_E_DIR_RST 4'hf
`define MGP_ADC1_RST 8'h00
`define MGP_ADC1_MASK 8'hef
`define MGP_TIMER_CAPTURE_CONTROL_THREE_RST 8'h00
`define MGP_TIMER_CAPTURE_CONTROL_THREE_MASK 8'h7f
`define MGP_PCFG_ALL_DIG 4'he
`endif

/* common/mgp_pkg.sv */
// types for the multiplexed gpio ports e/f/g/h block
package mgp_pkg;
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [3:0] bank;
      logic [4:0] addr;
      logic [7:0] wrData;
   } mgp_bus_t;

   typedef struct packed {
      logic [3:0] eDir;
      logic [3:0] eLat;
      logic [7:0] fDir;
      logic [7:0] fLat;
      logic [7:0] gDir;
      logic [7:0] gLat;
      logic [7:0] hDir;
      logic [7:0] hLat;
      logic [7:0] adcCon1;
      logic [7:0] timer_capture_control_three;
      logic [7:0] rdData;
      logic [3:0] eOut;
      logic [3:0] eOeN;
      logic [7:0] fOut;
      logic [7:0] fOeN;
      logic [7:0] gOut;
      logic [7:0] gOeN;
      logic [7:0] hOut;
      logic [7:0] hOeN;
      logic [11:0] anaSel;
      logic [3:0] anaSelHi;
      logic cap3In;
      logic cap4In;
      logic rx2In;
      logic ck2In;
   } mgp_state_t;
endpackage : mgp_pkg

/* bench/mgp_pin_model.sv */
// outside circuitry that sits on the port pins
`timescale 1ns/1ps
module mgp_pin_model (
   input wire logic [27:0] oeN,
   input wire logic [27:0] out,
   input wire logic [27:0] ext,
   output logic [27:0] pin
);
   // block driver wins; released pins show the outside level, never the latch
   always_comb begin
      for (int i = 0; i < 28; i++) begin
         pin[i] = oeN[i] ? ext[i] : out[i];
      end
   end
endmodule : mgp_pin_model

/* bench/mgp_ports_chk.sv */
// assertion checker for the gpio port block
`timescale 1ns/1ps
module mgp_ports_chk
   import mgp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire mgp_bus_t bus,
   input wire logic [7:0] rdData,
   input wire logic busMode,
   input wire logic busAle,
   input wire logic busOeN,
   input wire logic busWrN,
   input wire logic [15:0] capFourValue,
   input wire logic [3:0] portEOut,
   input wire logic [3:0] portEOeN,
   input wire logic [7:0] portFIn,
   input wire logic [7:0] portFOut,
   input wire logic [7:0] portFOeN,
   input wire logic [7:0] portGIn,
   input wire logic [7:0] portGOeN,
   input wire logic [7:0] portHOeN,
   input wire logic [11:0] analogSel,
   input wire logic [3:0] analogSelHigh,
   input wire logic captureThreeIn,
   input wire logic serialTwoRx,
   input wire logic [3:0] portConfig
);
   logic fAcc;
   assign fAcc = bus.bank == 4'h5 && portConfig == 4'he;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_reset_off: assert property (
      $fell(rst) |-> &{portEOeN, portFOeN, portGOeN, portHOeN})
      else $error("pins driving after reset");
   a_reset_analog: assert property (
      $fell(rst) |-> &analogSel && &analogSelHigh)
      else $error("pins not analog after reset");
   a_dir_sets_oe: assert property (
      bus.wrEn && fAcc && bus.addr == 5'h10 |=> portFOeN == $past(bus.wrData))
      else $error("direction write not seen on enables");
   a_latch_drives: assert property (
      bus.wrEn && fAcc && bus.addr == 5'h11
      |=> (portFOut & ~portFOeN) == ($past(bus.wrData) & ~portFOeN))
      else $error("latch not driven on output pins");
   a_pin_read: assert property (
      bus.rdEn && fAcc && bus.addr == 5'h11 |=> rdData == $past(portFIn))
      else $error("pin read wrong");
   a_idle_zero: assert property (!bus.rdEn |=> rdData == 8'h00)
      else $error("read data without read");
   a_unimpl_zero: assert property (
      bus.rdEn && bus.bank == 4'h1 && bus.addr == 5'h15 |=> rdData[7:4] == 4'h0)
      else $error("unimplemented bits not zero");
   a_cap_low: assert property (
      bus.rdEn && bus.bank == 4'h7 && bus.addr == 5'h14
      |=> rdData == $past(capFourValue[7:0]))
      else $error("capture low byte wrong");
   a_strobe_pass: assert property (
      $past(busMode) && !$past(rst) |-> portEOeN[2:0] == 3'b000 &&
      portEOut[2:0] == {$past(busWrN), $past(busOeN), $past(busAle)})
      else $error("bus strobes not on port e");
   a_periph_in: assert property (
      !$past(rst) |-> captureThreeIn == $past(portGIn[4]) &&
      serialTwoRx == $past(portGIn[6]))
      else $error("peripheral input not from pin");
   cover property (bus.wrEn && fAcc && bus.addr == 5'h11);
   cover property (busMode && $past(busMode));
   cover property ($fell(rst));
endmodule : mgp_ports_chk
bind mgp_ports mgp_ports_chk mgp_ports_chk_i (.sys_clk, .rst, .bus, .rdData,
   .busMode, .busAle, .busOeN, .busWrN, .capFourValue, .portEOut, .portEOeN,
   .portFIn, .portFOut, .portFOeN, .portGIn, .portGOeN, .portHOeN,
   .analogSel, .analogSelHigh, .captureThreeIn, .serialTwoRx, .portConfig);

/* bench/mgp_ports_bench.sv */
// self-checking bench for the gpio port block
`timescale 1ns/1ps
module mgp_ports_bench;
   import mgp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   mgp_bus_t bus = '0;
   logic busMode = 1'b0, busAle = 1'b1, busOeN = 1'b0, busWrN = 1'b1;
   logic pwmThree = 1'b0;
   logic serialTwoTxOe = 1'b0, serialTwoTx = 1'b0;
   logic serialTwoDtOe = 1'b0, serialTwoDt = 1'b0;
   logic captureThreeIn, captureFourIn, serialTwoRx, serialTwoClkIn;
   logic [15:0] capFourValue = 16'hbeef;
   logic [27:0] ext = {8'h96, 8'hc7, 8'h5a, 4'h3};
   logic [7:0] rdData, portFOut, portFOeN, portGOut, portGOeN, got;
   logic [7:0] portHOut, portHOeN;
   logic [3:0] portEOut, portEOeN, analogSelHigh, portConfig;
   logic [11:0] analogSel;
   logic [27:0] pin;
   logic pwmThreeEnable;
   int err_total = 0, samples_checked = 0;
   always #10 sys_clk = ~sys_clk;
   mgp_pin_model mgp_pin_model_i (.ext, .pin,
      .oeN({portHOeN, portGOeN, portFOeN, portEOeN}),
      .out({portHOut, portGOut, portFOut, portEOut}));
   mgp_ports mgp_ports_i (.sys_clk, .rst, .bus, .rdData, .busMode, .busAle,
      .busOeN, .busWrN, .capFourValue, .pwmThree, .serialTwoTxOe,
      .serialTwoTx, .serialTwoDtOe, .serialTwoDt,
      .portEIn(pin[3:0]), .portEOut, .portEOeN, .portFIn(pin[11:4]),
      .portFOut, .portFOeN, .portGIn(pin[19:12]), .portGOut, .portGOeN,
      .portHIn(pin[27:20]), .portHOut, .portHOeN, .analogSel, .analogSelHigh,
      .captureThreeIn, .captureFourIn, .serialTwoRx,
      .serialTwoClkIn, .portConfig, .pwmThreeEnable);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // one access, then an idle cycle so strobes never toggle in one step
   task automatic acc(input logic w, input logic [3:0] b,
         input logic [4:0] a, input logic [7:0] d);
      bus = '{w, !w, b, a, d};
      @(posedge sys_clk) #1;
      bus = '0;
      got = rdData;
      @(posedge sys_clk) #1;
   endtask : acc
   task automatic rd(input logic [3:0] b, input logic [4:0] a,
         input logic [7:0] e);
      acc(1'b0, b, a, 8'h00);
      check(got, e);
   endtask : rd
   task automatic reset_check;
      rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 rst = 1'b0;
      check(analogSel, 12'hfff);
      check(analogSelHigh, 4'hf);
      rd(4'h5, 5'h10, 8'hff);
      rd(4'h5, 5'h11, 8'h00);
      rd(4'h5, 5'h12, 8'hff);
      rd(4'h1, 5'h14, 8'h0f);
      rd(4'h8, 5'h10, 8'hff);
      rd(4'h5, 5'h15, 8'h00);
      rd(4'h7, 5'h16, 8'h00);
      check(portFOut, 8'h00);
   endtask : reset_check
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      reset_check;
      acc(1'b1, 4'h5, 5'h15, 8'hff);
      rd(4'h5, 5'h15, 8'hef);
      acc(1'b1, 4'h5, 5'h15, 8'h0e);
      check(portConfig, 4'he);
      check(analogSel, 12'h000);
      check(analogSelHigh, 4'h0);
      acc(1'b1, 4'h5, 5'h11, 8'h00);
      acc(1'b1, 4'h5, 5'h10, 8'h03);
      check(portFOeN, 8'h03);
      acc(1'b1, 4'h5, 5'h11, 8'ha4);
      check(portFOut | 8'h03, 8'ha7);
      rd(4'h5, 5'h11, 8'ha6);
      acc(1'b1, 4'h8, 5'h11, 8'h00);
      acc(1'b1, 4'h8, 5'h10, 8'h00);
      acc(1'b1, 4'h8, 5'h11, 8'h3c);
      rd(4'h8, 5'h11, 8'h3c);
      acc(1'b1, 4'h5, 5'h15, 8'h00);
      check(analogSel, 12'hfff);
      rd(4'h5, 5'h13, 8'hc0);
      acc(1'b1, 4'h5, 5'h15, 8'h0e);
      pwmThree = 1'b1;
      acc(1'b1, 4'h7, 5'h16, 8'hff);
      rd(4'h7, 5'h16, 8'h1f);
      check(pwmThreeEnable, 1'b1);
      check({portGOut[5], portGOeN[5]}, 2'b10);
      rd(4'h7, 5'h14, 8'hef);
      rd(4'h7, 5'h15, 8'hbe);
      acc(1'b1, 4'h7, 5'h14, 8'h00);
      rd(4'h7, 5'h14, 8'hef);
      rd(4'h3, 5'h10, 8'h00);
      busMode = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 check({portEOut[2:0], portEOeN[2:0]}, 6'h28);
      rd(4'h1, 5'h15, 8'h05);
      busMode = 1'b0;
      // latch before direction, so e3 and g4 come up driving ones
      acc(1'b1, 4'h1, 5'h15, 8'h08);
      acc(1'b1, 4'h1, 5'h14, 8'h07);
      check(portEOeN, 4'h7);
      acc(1'b1, 4'h5, 5'h13, 8'h10);
      acc(1'b1, 4'h5, 5'h12, 8'hef);
      {serialTwoTxOe, serialTwoTx, serialTwoDtOe, serialTwoDt} = 4'he;
      repeat (2) @(posedge sys_clk);
      #1 check({portGOut[7:6], portGOeN[7:6]}, 4'h8);
      check({serialTwoRx, serialTwoClkIn}, 2'b01);
      check({captureThreeIn, captureFourIn}, 2'b11);
      rd(4'h5, 5'h13, 8'hb7);
      rd(4'h1, 5'h15, 8'h0b);
      {serialTwoTxOe, serialTwoTx, serialTwoDtOe, serialTwoDt} = 4'h0;
      reset_check;
      check(portEOut, 4'h8);
      finish_test;
   end
endmodule : mgp_ports_bench
